/* File: prc_defines.vh */
`ifndef PRC_DEFINES_VH
`define PRC_DEFINES_VH
`define PRC_REG_BASE_HI     8'h40
`define PRC_REG_BASE_LO     8'h41
`define PRC_REG_BOOT_WIDTH  8'h42
`define PRC_REG_BOOT_SZ_HI  8'h43
`define PRC_REG_BOOT_SZ_LO  8'h44
`define PRC_REG_SH_BASE_HI  8'h48
`define PRC_REG_SH_BASE_LO  8'h49
`define PRC_REG_SH_WIDTH    8'h4A
`define PRC_REG_SH_SZ_HI    8'h4B
`define PRC_REG_SH_SZ_LO    8'h4C
`define PRC_REG_VENDOR      8'hF0
`define PRC_REG_PORT_HI     8'h60
`define PRC_REG_PORT_LO     8'h61
`define PRC_VB_PORT_WIDE    0
`define PRC_VB_EXT_DECODE   1
`define PRC_VB_ADDR_ROM     2
`define PRC_VB_BOOT_UPPER   3
`define PRC_VB_FLASH        4
`define PRC_VB_XCVR_POL     5
`define PRC_VB_FIXED_CFG    6
`define PRC_WIDE_BIT        1
`define PRC_LAST_WORD       5'h1B
`define PRC_VENDOR_WORD     5'h1A
`define PRC_SUM_GOOD        8'hFF
`define PRC_CONST_40        8'h0C
`define PRC_CONST_SZ_HI     8'hFE
`define PRC_CONST_SH_HI     8'h0C
`define PRC_CONST_PORT_HI   8'h02
`endif

/* File: prc_resource_decode.v */
`timescale 1ns/10ps
`include "prc_defines.vh"
// configuration registers and memory/port decode; only the vendor byte is loaded from the serial store
module prc_resource_decode (
	input  wire        mclk_in,          // 40 MHz clock
	input  wire        rstn_in,          // sync reset, active low
	input  wire        cfg_wr_in,        // config register write strobe
	input  wire [7:0]  cfg_addr_in,      // config register index
	input  wire [7:0]  cfg_wdata_in,     // config write data
	output reg  [7:0]  cfg_rdata_out,    // config read data
	input  wire        ee_present_in,    // serial store fitted (busy pin connected)
	input  wire        ee_valid_in,      // one word of load data this cycle
	input  wire [15:0] ee_word_in,       // load word
	input  wire [4:0]  ee_index_in,      // load word index
	input  wire        ee_done_in,       // store read through chain end
	input  wire        key_std_in,       // standard initiation key seen
	input  wire        key_alt_in,       // alternate vendor key seen
	output reg         key_accept_out,   // wake from wait-for-key
	output reg         reloc_mode_out,   // software relocatable mode
	output reg         scan_chain_busy_out, // external chain busy
	input  wire        bus_master_in,    // bus master architecture
	input  wire        shared_mode_in,   // shared memory architecture
	input  wire [19:0] sa_in,            // ISA address
	input  wire        bale_in,          // address latch / upper select
	input  wire        memr_n_in,        // memory read, active low
	input  wire        memw_n_in,        // memory write, active low
	input  wire        aen_in,           // address enable
	input  wire        tp_active_in,     // twisted pair active or sleep
	input  wire        ioread_n_in,      // port read, active low
	output reg         boot_rom_select_n_out, // boot rom / flash select
	output reg         boot_wide_out,    // boot cycle answered 16-bit
	output reg         shared_hit_out,   // shared memory decode
	output reg         shared_wide_out,  // shared cycle 16-bit
	output reg         port_hit_out,     // port selected
	output reg         iocs16_n_out,     // 16-bit port select, active low
	output reg         addr_rom_select_n_out, // parallel addr rom select (irq15 pin)
	output reg         addr_ram_read_out,// serve address from internal ram
	output reg         irq12_pin_out,    // flash we or sram cs, active low
	output reg         xcvr_enable_pin_out // transceiver enable
);
	reg [3:0] boot_rom_base_match_q;
	reg       boot_rom_wide_access_q;
	reg [3:0] boot_rom_size_field_q;
	reg [4:0] shared_mem_base_q;
	reg       shared_mem_wide_access_q;
	reg [3:0] shared_mem_size_field_q;
	reg [3:0] port_base_match_q;
	reg [7:0] vendor_q;
	reg [7:0] sum_q;
	reg       loading_q;
	reg       good_q;
	reg       upper_q;

	function [3:0] size_mask;
		input [3:0] f;
		begin
			case (f)
			4'hF:    size_mask = 4'hF;
			4'hE:    size_mask = 4'hE;
			4'hC:    size_mask = 4'hC;
			4'h8:    size_mask = 4'h8;
			default: size_mask = 4'h0;
			endcase
		end
	endfunction

	wire [3:0] bmask = size_mask(boot_rom_size_field_q);
	wire [3:0] smask = size_mask(shared_mem_size_field_q);
	wire       flash = vendor_q[`PRC_VB_FLASH];
	// upper select by latched address or BALE low
	wire       upper_ok = vendor_q[`PRC_VB_BOOT_UPPER] ? ~bale_in : upper_q;
	wire       boot_hit = (bmask != 4'h0) && upper_ok &&
		(((sa_in[16:13] ^ boot_rom_base_match_q) & bmask) == 4'h0);
	// shared base compare on SA[15:13]; gates modes
	wire       sh_hit = shared_mode_in && !bus_master_in && (smask != 4'h0) &&
		(((sa_in[15:13] ^ shared_mem_base_q[2:0]) & smask[2:0]) == 3'h0);
	wire       port_sel = vendor_q[`PRC_VB_EXT_DECODE] ? ~aen_in :
		(~aen_in && sa_in[9] && (sa_in[8:5] == port_base_match_q));
	wire       addr_space = port_sel && (sa_in[4] == 1'b0);

	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			boot_rom_base_match_q    <= 4'h0;
			boot_rom_wide_access_q   <= 1'b0;
			boot_rom_size_field_q    <= 4'h0;
			shared_mem_base_q        <= 5'h00;
			shared_mem_wide_access_q <= 1'b0;
			shared_mem_size_field_q  <= 4'h0;
			port_base_match_q        <= 4'h0;
			vendor_q                 <= 8'h00;
			sum_q                    <= 8'h00;
			loading_q                <= 1'b1;
			good_q                   <= 1'b0;
			upper_q                  <= 1'b0;
		end else begin
			if (bale_in)
				upper_q <= (sa_in[19:17] == 3'h6);
			if (loading_q && ee_valid_in && ee_index_in <= `PRC_LAST_WORD) begin
				sum_q <= sum_q + ee_word_in[7:0] + ee_word_in[15:8];
				if (ee_index_in == `PRC_VENDOR_WORD)
					vendor_q <= {1'b0, ee_word_in[6:0]};
			end
			// a missing store ends the load at once
			if (loading_q && (ee_done_in || !ee_present_in)) begin
				loading_q <= 1'b0;
				// missing store is a failed load
				good_q    <= ee_present_in && (sum_q == `PRC_SUM_GOOD);
			end
			if (cfg_wr_in) begin
				case (cfg_addr_in)
				`PRC_REG_BASE_HI:    boot_rom_base_match_q[3] <= cfg_wdata_in[0];
				`PRC_REG_BASE_LO:    boot_rom_base_match_q[2:0] <= cfg_wdata_in[7:5];
				`PRC_REG_BOOT_WIDTH: boot_rom_wide_access_q <= cfg_wdata_in[`PRC_WIDE_BIT];
				`PRC_REG_BOOT_SZ_HI: boot_rom_size_field_q[3] <= cfg_wdata_in[0];
				`PRC_REG_BOOT_SZ_LO: boot_rom_size_field_q[2:0] <= cfg_wdata_in[7:5];
				`PRC_REG_SH_BASE_HI: shared_mem_base_q[4:3] <= cfg_wdata_in[1:0];
				`PRC_REG_SH_BASE_LO: shared_mem_base_q[2:0] <= cfg_wdata_in[7:5];
				`PRC_REG_SH_WIDTH:   shared_mem_wide_access_q <= cfg_wdata_in[`PRC_WIDE_BIT];
				`PRC_REG_SH_SZ_HI:   shared_mem_size_field_q[3] <= cfg_wdata_in[0];
				`PRC_REG_SH_SZ_LO:   shared_mem_size_field_q[2:0] <= cfg_wdata_in[7:5];
				`PRC_REG_PORT_HI:    port_base_match_q[3] <= cfg_wdata_in[0];
				`PRC_REG_PORT_LO:    port_base_match_q[2:0] <= cfg_wdata_in[7:5];
				`PRC_REG_VENDOR:     vendor_q <= {1'b0, cfg_wdata_in[6:0]};
				default: ;
				endcase
			end
		end
	end

	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			cfg_rdata_out         <= 8'h00;
			key_accept_out        <= 1'b0;
			reloc_mode_out        <= 1'b0;
			scan_chain_busy_out   <= 1'b1;
			boot_rom_select_n_out <= 1'b1;
			boot_wide_out         <= 1'b0;
			shared_hit_out        <= 1'b0;
			shared_wide_out       <= 1'b0;
			port_hit_out          <= 1'b0;
			iocs16_n_out          <= 1'b1;
			addr_rom_select_n_out <= 1'b1;
			addr_ram_read_out     <= 1'b0;
			irq12_pin_out         <= 1'b1;
			xcvr_enable_pin_out   <= 1'b1;
		end else begin
			case (cfg_addr_in)
			`PRC_REG_BASE_HI:    cfg_rdata_out <= `PRC_CONST_40 | {7'h00, boot_rom_base_match_q[3]};
			`PRC_REG_BASE_LO:    cfg_rdata_out <= {boot_rom_base_match_q[2:0], 5'h00};
			`PRC_REG_BOOT_WIDTH: cfg_rdata_out <= {6'h00, boot_rom_wide_access_q, 1'b0};
			`PRC_REG_BOOT_SZ_HI: cfg_rdata_out <= `PRC_CONST_SZ_HI | {7'h00, boot_rom_size_field_q[3]};
			`PRC_REG_BOOT_SZ_LO: cfg_rdata_out <= {boot_rom_size_field_q[2:0], 5'h00};
			`PRC_REG_SH_BASE_HI: cfg_rdata_out <= `PRC_CONST_SH_HI | {6'h00, shared_mem_base_q[4:3]};
			`PRC_REG_SH_BASE_LO: cfg_rdata_out <= {shared_mem_base_q[2:0], 5'h00};
			`PRC_REG_SH_WIDTH:   cfg_rdata_out <= {6'h00, shared_mem_wide_access_q, 1'b0};
			`PRC_REG_SH_SZ_HI:   cfg_rdata_out <= `PRC_CONST_SZ_HI | {7'h00, shared_mem_size_field_q[3]};
			`PRC_REG_SH_SZ_LO:   cfg_rdata_out <= {shared_mem_size_field_q[2:0], 5'h00};
			`PRC_REG_PORT_HI:    cfg_rdata_out <= `PRC_CONST_PORT_HI | {7'h00, port_base_match_q[3]};
			`PRC_REG_PORT_LO:    cfg_rdata_out <= {port_base_match_q[2:0], 5'h00};
			`PRC_REG_VENDOR:     cfg_rdata_out <= vendor_q;
			default:             cfg_rdata_out <= 8'h00;
			endcase
			// standard key only after good load
			key_accept_out <= key_alt_in ||
				(key_std_in && good_q && !vendor_q[`PRC_VB_FIXED_CFG]);
			reloc_mode_out <= !loading_q && !good_q;
			// busy falls only on good checksum
			scan_chain_busy_out <= loading_q ? 1'b1 : !good_q;
			// master flash oe; shared flash cs
			boot_rom_select_n_out <= !(boot_hit && (flash ? 1'b1 : !memr_n_in) &&
				(bus_master_in ? !memr_n_in : 1'b1));
			boot_wide_out <= boot_hit && boot_rom_wide_access_q && !bus_master_in;
			shared_hit_out <= sh_hit;
			shared_wide_out <= sh_hit && shared_mem_wide_access_q;
			port_hit_out <= port_sel;
			iocs16_n_out <= !(port_sel && vendor_q[`PRC_VB_PORT_WIDE]);
			addr_rom_select_n_out <= !(vendor_q[`PRC_VB_ADDR_ROM] && addr_space &&
				!ioread_n_in);
			addr_ram_read_out <= !vendor_q[`PRC_VB_ADDR_ROM] && addr_space && !ioread_n_in;
			irq12_pin_out <= !(flash && (bus_master_in ? (boot_hit && !memw_n_in) : sh_hit));
			xcvr_enable_pin_out <= tp_active_in ^ vendor_q[`PRC_VB_XCVR_POL];
		end
	end
endmodule // prc_resource_decode

/* File: prc_sva.sv */
`timescale 1ns/10ps
module prc_sva (
	input wire       mclk_in, rstn_in, key_std_in, key_alt_in, key_accept_out,
	input wire       reloc_mode_out, scan_chain_busy_out, ee_done_in, bus_master_in,
	input wire       shared_mode_in, boot_wide_out, shared_hit_out, shared_wide_out,
	input wire       port_hit_out, iocs16_n_out,
	input wire [7:0] cfg_addr_in, cfg_rdata_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	property p_alt_key; key_alt_in |=> key_accept_out; endproperty
	a_alt_key: assert property (p_alt_key) else $error("alternate key refused");
	property p_std_reloc; key_std_in && !key_alt_in && reloc_mode_out |=> !key_accept_out; endproperty
	a_std_reloc: assert property (p_std_reloc) else $error("standard key taken in reloc");
	property p_busy_fall;
		$fell(scan_chain_busy_out) |-> $past(ee_done_in) || $past(ee_done_in, 2) || $past(ee_done_in, 3);
	endproperty
	a_busy_fall: assert property (p_busy_fall) else $error("busy fell without chain end");
	property p_reloc_busy; reloc_mode_out |-> scan_chain_busy_out; endproperty
	a_reloc_busy: assert property (p_reloc_busy) else $error("busy low on bad load");
	property p_boot8; bus_master_in |=> !boot_wide_out; endproperty
	a_boot8: assert property (p_boot8) else $error("wide boot cycle in master mode");
	property p_sh_off; bus_master_in || !shared_mode_in |=> !shared_hit_out && !shared_wide_out; endproperty
	a_sh_off: assert property (p_sh_off) else $error("shared decode outside shared mode");
	property p_io16; !iocs16_n_out |-> port_hit_out; endproperty
	a_io16: assert property (p_io16) else $error("port select without hit");
	property p_vend7; cfg_addr_in == 8'hF0 |=> !cfg_rdata_out[7]; endproperty
	a_vend7: assert property (p_vend7) else $error("vendor bit 7 reads one");
endmodule // prc_sva
bind prc_resource_decode prc_sva i_prc_sva (.mclk_in, .rstn_in, .key_std_in, .key_alt_in,
	.key_accept_out, .reloc_mode_out, .scan_chain_busy_out, .ee_done_in, .bus_master_in,
	.shared_mode_in, .boot_wide_out, .shared_hit_out, .shared_wide_out, .port_hit_out,
	.iocs16_n_out, .cfg_addr_in, .cfg_rdata_out);

/* File: prc_ee_model.sv */
`timescale 1ns/10ps
// serial store: streams words 1..1Bh then word 0, then marks the chain end
module prc_ee_model (
	input  wire        clk_in,    // device clock
	input  wire        start_in,  // begin a load
	input  wire        bad_in,    // spoil the checksum
	input  wire [7:0]  vend_in,   // vendor byte of word 1Ah
	input  wire        busy_in,   // chain busy from device
	output reg         valid_out, // word strobe
	output reg  [15:0] word_out,  // load word
	output reg  [4:0]  index_out, // word index
	output reg         done_out,  // end of chain
	output reg  [15:0] chain_out  // external chain latch
);
	integer    i;
	reg [7:0]  s;
	reg [15:0] w;
	initial {valid_out, word_out, index_out, done_out, chain_out} = 39'h0;
	always @(negedge busy_in) chain_out <= word_out;
	// word 0 closes the byte sum at FFh
	always @(posedge start_in) begin
		s = {7'h00, bad_in};
		for (i = 1; i < 29; i = i + 1) begin
			w = (i == 28) ? {8'h00, 8'hFF - s} : (i == 26) ? {8'h3C, vend_in} :
				{i[7:0] * 8'h13, i[7:0] + 8'h21};
			s = s + w[15:8] + w[7:0];
			@(posedge clk_in);
			valid_out <= 1'b1;
			index_out <= (i == 28) ? 5'h00 : i[4:0];
			word_out <= w;
		end
		@(posedge clk_in);
		valid_out <= 1'b0;
		done_out <= 1'b1;
		word_out <= ~w;
		@(posedge clk_in);
		done_out <= 1'b0;
	end
endmodule // prc_ee_model

/* File: testbench.sv */
`timescale 1ns/10ps
`include "prc_defines.vh"
module testbench;
	reg         mclk_in = 0, rstn_in = 0, wr = 0, present = 1, start = 0, bad = 0, kstd = 0;
	reg         kalt = 0, bm = 0, shm = 0, bale = 0, memr_n = 1, memw_n = 1, aen = 1, ior_n = 1;
	reg         tp = 0;
	reg  [7:0]  addr = 0, wdata = 0, vend = 0, a;
	reg  [19:0] sa = 0;
	wire [7:0]  rdata;
	wire [15:0] ew;
	wire [4:0]  ei;
	wire        ev, edone, kacc, reloc, busy, xcvr;
	wire        bw, shh, shw, ph, io16n, arsn, arr;
	reg  [27:0] cur, old;
	reg  [7:0]  vd;
	reg         p, sh;
	integer     n_errors = 0, tests_run = 0, seed = 15, i, r;
	integer     mdl [0:255];
	always #12.5 mclk_in = ~mclk_in;
	prc_ee_model i_prc_ee_model (.clk_in(mclk_in), .start_in(start), .bad_in(bad),
		.vend_in(vend), .busy_in(busy), .valid_out(ev), .word_out(ew), .index_out(ei),
		.done_out(edone), .chain_out());
	prc_resource_decode i_prc_resource_decode (.mclk_in(mclk_in), .rstn_in(rstn_in),
		.cfg_wr_in(wr), .cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata),
		.ee_present_in(present), .ee_valid_in(ev), .ee_word_in(ew), .ee_index_in(ei),
		.ee_done_in(edone), .key_std_in(kstd), .key_alt_in(kalt), .key_accept_out(kacc),
		.reloc_mode_out(reloc), .scan_chain_busy_out(busy), .bus_master_in(bm),
		.shared_mode_in(shm), .sa_in(sa), .bale_in(bale), .memr_n_in(memr_n),
		.memw_n_in(memw_n), .aen_in(aen), .tp_active_in(tp), .ioread_n_in(ior_n),
		.boot_rom_select_n_out(), .boot_wide_out(bw), .shared_hit_out(shh),
		.shared_wide_out(shw), .port_hit_out(ph), .iocs16_n_out(io16n),
		.addr_rom_select_n_out(arsn), .addr_ram_read_out(arr),
		.irq12_pin_out(), .xcvr_enable_pin_out(xcvr));
	task chk(input string nm, input [7:0] e, input [7:0] g);
		tests_run = tests_run + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task close_out;
		$display("comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task do_reset;
		rstn_in <= 0;
		repeat (20) @(posedge mclk_in);
		rstn_in <= 1;
		for (i = 0; i < 256; i = i + 1) mdl[i] = 0;
	endtask
	task wr_reg(input [7:0] ad, input [7:0] d);
		wr <= 1;
		addr <= ad;
		wdata <= d;
		@(posedge mclk_in);
		wr <= 0;
		mdl[ad] = d & ((ad == `PRC_REG_VENDOR) ? 8'h7F : (ad == `PRC_REG_BOOT_WIDTH) ? 8'h02 : 8'h00);
	endtask
	task rd(input [7:0] ad);
		addr <= ad;
		@(posedge mclk_in);
		#1 chk("cfg_rdata", mdl[ad], rdata);
	endtask
	task key(input s, input al, input e);
		kstd <= s;
		kalt <= al;
		@(posedge mclk_in);
		kstd <= 0;
		kalt <= 0;
		#1 chk("key_accept", e, kacc);
	endtask
	task load(input b, input [7:0] v);
		@(posedge mclk_in);
		bad <= b;
		vend <= v;
		start <= 1;
		@(posedge mclk_in);
		start <= 0;
		repeat (10) @(posedge mclk_in);
		#1 chk("busy", 1, busy);
		repeat (30) @(posedge mclk_in);
		#1 chk("busy", b, busy);
		chk("reloc", b, reloc);
		if (!b) mdl[`PRC_REG_VENDOR] = v & 8'h7F;
		$display("load test done, spoiled %0d", b);
	endtask
	initial begin
		#(25 * 3000);
		n_errors = n_errors + 1;
		close_out;
	end
	initial begin
		do_reset;
		rd(`PRC_REG_VENDOR);
		r = $random(seed);
		load(0, r[7:0] & 8'hBF);
		rd(`PRC_REG_VENDOR);
		key(1, 0, 1);
		wr_reg(`PRC_REG_VENDOR, 8'h40 | mdl[`PRC_REG_VENDOR][7:0]);
		key(1, 0, 0);
		key(0, 1, 1);
		$display("key test done");
		for (i = 0; i < 12; i = i + 1) begin
			r = $random(seed);
			a = (i % 3 == 0) ? `PRC_REG_VENDOR : (i % 3 == 1) ? `PRC_REG_BOOT_WIDTH : 8'h50;
			wr_reg(a, r[7:0]);
			rd(a);
			tp <= r[8];
			repeat (2) @(posedge mclk_in);
			#1 chk("xcvr", {7'h00, r[8] ^ mdl[`PRC_REG_VENDOR][5]}, {7'h00, xcvr});
		end
		$display("register test done");
		wr_reg(`PRC_REG_SH_BASE_HI, 8'h00);
		wr_reg(`PRC_REG_SH_SZ_HI, 8'h01);
		wr_reg(`PRC_REG_SH_SZ_LO, 8'hE0);
		wr_reg(`PRC_REG_SH_WIDTH, 8'h02);
		cur = {sa, bale, memr_n, memw_n, aen, ior_n, bm, shm, tp};
		repeat (400) begin
			@(posedge mclk_in);
			old = cur;
			r = $random(seed);
			cur = r[27:0];
			{sa, bale, memr_n, memw_n, aen, ior_n, bm, shm, tp} <= cur;
			#1 vd = mdl[`PRC_REG_VENDOR];
			p = !old[4] && (vd[1] || (old[17] && old[16:13] == 4'h0));
			sh = old[1] && !old[2] && old[23:21] == 3'h0;
			chk("port_hit", {7'h00, p}, {7'h00, ph});
			chk("iocs16_n", {7'h00, !(p && vd[0])}, {7'h00, io16n});
			chk("shared_hit", {7'h00, sh}, {7'h00, shh});
			chk("shared_wide", {7'h00, sh}, {7'h00, shw});
			chk("boot_wide", 8'h00, {7'h00, bw});
			chk("addr_rom_sel_n", {7'h00, !(vd[2] && p && !old[12] && !old[3])},
				{7'h00, arsn});
			chk("addr_ram_read", {7'h00, !vd[2] && p && !old[12] && !old[3]},
				{7'h00, arr});
			chk("xcvr", {7'h00, old[0] ^ vd[5]}, {7'h00, xcvr});
		end
		$display("decode traffic done");
		do_reset;
		load(1, 8'h00);
		key(1, 0, 0);
		key(0, 1, 1);
		present <= 0;
		do_reset;
		repeat (5) @(posedge mclk_in);
		#1 chk("reloc", 1, reloc);
		$display("no store test done");
		close_out;
	end
endmodule // testbench
